/* File: pkg/osc_switch_pkg.sv */
// Purpose: Shared constants and types for the oscillator switch request block
// Assumes: AXI4-Lite slave with 32-bit data, 8-bit byte addresses
// Notes:   Every offset, field position, reset value and count lives here
package osc_switch_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int              ADDR_W          = 8;
  localparam logic [7:0]      REQ_OFS         = 8'h00;
  localparam logic [7:0]      STATUS_OFS      = 8'h04;
  localparam logic [7:0]      STARTUP_OFS     = 8'h08;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int              SRC_LSB         = 4;
  localparam int              SRC_MSB         = 6;
  localparam int              DIV_LSB         = 0;
  localparam int              DIV_MSB         = 3;
  localparam int              STABLE_BIT      = 0;
  localparam int              COUNTING_BIT    = 1;
  localparam logic [2:0]      HF4_SRC_CODE    = 3'h6;
  localparam logic [3:0]      HF4_RESET_DIV   = 4'h2;
  localparam logic [3:0]      OTHER_RESET_DIV = 4'h0;
  localparam logic [7:0]      RESERVED_SRC    = 8'h18;

  // ----------------------------------------------------------------
  // Start-up counting
  // ----------------------------------------------------------------
  localparam int              OST_COUNT       = 1024;
  localparam int              OST_W           = 11;

  // ----------------------------------------------------------------
  // Bus responses and crystal configuration codes
  // ----------------------------------------------------------------
  localparam logic [1:0]      RESP_OKAY       = 2'h0;
  localparam logic [1:0]      RESP_SLVERR     = 2'h2;
  localparam logic [1:0]      XTAL_NONE       = 2'h0;
  localparam logic [1:0]      XTAL_LOW_POWER  = 2'h1;
  localparam logic [1:0]      XTAL_MEDIUM     = 2'h2;
  localparam logic [1:0]      XTAL_HIGH_SPEED = 2'h3;

  typedef enum logic [1:0] {
    ST_COUNT  = 2'b01,
    ST_STABLE = 2'b10
  } ost_state_type;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_type;

endpackage

/* File: design/osc_switch_ctrl.sv */
// Purpose: Clock source switch request, active status and crystal start-up count
// Assumes: Configuration inputs are static while out of reset
// Notes:   One clock domain; the crystal pin is sampled through three flops
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps

// Functional notes
// - Crystal modes count 1024 crystal cycles before the clock counts as stable.
// - Start-up count runs after power-on, brown-out reset and each wake-up.
// - Non-crystal configurations never wait on the start-up count.
// - Request bits 6..4 hold the software-requested source and PLL combination.
// - Request bits 3..0 hold the requested postscaler division ratio.
// - A reserved source code discards the whole write, both fields unchanged.
// - With switch write enable low the request register is read-only.
// - Requested source resets from the reset source configuration bits.
// - Divider resets to 0010 for source 110, else 0000.
// - Status bits 6..4 show the active source; writes do nothing.
// - Status bits 3..0 show the active divider; writes do nothing.
// - Status reset value equals the request reset value.
// - Status value is the one present once start-up delays finish.
// - Bit 7 of request and status always reads zero.
module osc_switch_ctrl #(
  parameter int         OST_CYCLES   = osc_switch_pkg::OST_COUNT,
  parameter logic [7:0] RESERVED_MAP = osc_switch_pkg::RESERVED_SRC
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire osc_switch_pkg::axi_req_type s_axi_req,
  output osc_switch_pkg::axi_rsp_type      s_axi_rsp,
  input  wire logic [2:0]                  reset_source_config,
  input  wire logic                        switch_write_enable,
  input  wire logic [1:0]                  crystal_mode_cfg,
  input  wire logic                        wake_pulse,
  input  wire logic                        crystal_input_pin,
  output logic                             clock_stable,
  output logic [2:0]                       active_source_sel,
  output logic [3:0]                       active_divider_sel
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                        aw_held;
    logic [osc_switch_pkg::ADDR_W-1:0] aw_addr;
    logic                        w_held;
    logic [31:0]                 w_data;
    logic [3:0]                  w_strb;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        rvalid;
    logic [1:0]                  rresp;
    logic [31:0]                 rdata;
    logic [2:0]                  requested_source_sel;
    logic [3:0]                  requested_divider_sel;
    logic [2:0]                  active_source_sel;
    logic [3:0]                  active_divider_sel;
    logic [2:0]                  pin_sync;
    logic                        pin_level;
    logic [osc_switch_pkg::OST_W-1:0] startup_oscillation_counter;
    osc_switch_pkg::ost_state_type ost_state;
  } state_type;

  state_type state_q;
  state_type state_d;

  logic                              crystal_mode;
  logic                              pin_rise;
  logic                              aw_fire;
  logic                              w_fire;
  logic                              ar_fire;
  logic                              wr_fire;
  logic [osc_switch_pkg::ADDR_W-1:0] wr_addr;
  logic [31:0]                       wr_data;
  logic [3:0]                        wr_strb;
  logic [3:0]                        reset_div;
  logic [osc_switch_pkg::OST_W-1:0]  ost_last;

  assign crystal_mode = (crystal_mode_cfg != osc_switch_pkg::XTAL_NONE);
  assign reset_div    = (reset_source_config == osc_switch_pkg::HF4_SRC_CODE) ?
                        osc_switch_pkg::HF4_RESET_DIV : osc_switch_pkg::OTHER_RESET_DIV;
  assign ost_last     = osc_switch_pkg::OST_W'(OST_CYCLES - 1);
  assign pin_rise     = (state_q.pin_sync[1] == state_q.pin_sync[2]) &&
                        state_q.pin_sync[1] && !state_q.pin_level;

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  assign s_axi_rsp.awready = !state_q.aw_held && !state_q.bvalid;
  assign s_axi_rsp.wready  = !state_q.w_held && !state_q.bvalid;
  assign s_axi_rsp.bvalid  = state_q.bvalid;
  assign s_axi_rsp.bresp   = state_q.bresp;
  assign s_axi_rsp.arready = !state_q.rvalid;
  assign s_axi_rsp.rvalid  = state_q.rvalid;
  assign s_axi_rsp.rdata   = state_q.rdata;
  assign s_axi_rsp.rresp   = state_q.rresp;

  assign aw_fire = s_axi_req.awvalid && s_axi_rsp.awready;
  assign w_fire  = s_axi_req.wvalid && s_axi_rsp.wready;
  assign ar_fire = s_axi_req.arvalid && s_axi_rsp.arready;
  assign wr_fire = (state_q.aw_held || aw_fire) && (state_q.w_held || w_fire);
  assign wr_addr = state_q.aw_held ? state_q.aw_addr : s_axi_req.awaddr;
  assign wr_data = state_q.w_held ? state_q.w_data : s_axi_req.wdata;
  assign wr_strb = state_q.w_held ? state_q.w_strb : s_axi_req.wstrb;

  assign clock_stable       = (state_q.ost_state == osc_switch_pkg::ST_STABLE);
  assign active_source_sel  = state_q.active_source_sel;
  assign active_divider_sel = state_q.active_divider_sel;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    // Crystal pin filter
    state_d.pin_sync = {state_q.pin_sync[1:0], crystal_input_pin};
    if (state_q.pin_sync[1] == state_q.pin_sync[2]) begin
      state_d.pin_level = state_q.pin_sync[1];
    end
    // Write channel
    if (aw_fire) begin
      state_d.aw_held = 1'b1;
      state_d.aw_addr = s_axi_req.awaddr;
    end
    if (w_fire) begin
      state_d.w_held = 1'b1;
      state_d.w_data = s_axi_req.wdata;
      state_d.w_strb = s_axi_req.wstrb;
    end
    if (state_q.bvalid && s_axi_req.bready) begin
      state_d.bvalid = 1'b0;
    end
    if (wr_fire) begin
      state_d.aw_held = 1'b0;
      state_d.w_held  = 1'b0;
      state_d.bvalid  = 1'b1;
      state_d.bresp   = osc_switch_pkg::RESP_OKAY;
      if (wr_addr == osc_switch_pkg::REQ_OFS) begin
        if (switch_write_enable && wr_strb[0] &&
            !RESERVED_MAP[wr_data[osc_switch_pkg::SRC_MSB:osc_switch_pkg::SRC_LSB]]) begin
          state_d.requested_source_sel  =
            wr_data[osc_switch_pkg::SRC_MSB:osc_switch_pkg::SRC_LSB];
          state_d.requested_divider_sel =
            wr_data[osc_switch_pkg::DIV_MSB:osc_switch_pkg::DIV_LSB];
        end
      end else if (wr_addr == osc_switch_pkg::STATUS_OFS) begin
        state_d.bresp = osc_switch_pkg::RESP_OKAY;
      end else if (wr_addr == osc_switch_pkg::STARTUP_OFS) begin
        state_d.bresp = osc_switch_pkg::RESP_OKAY;
      end else begin
        state_d.bresp = osc_switch_pkg::RESP_SLVERR;
      end
    end
    // Read channel
    if (state_q.rvalid && s_axi_req.rready) begin
      state_d.rvalid = 1'b0;
    end
    if (ar_fire) begin
      state_d.rvalid = 1'b1;
      state_d.rresp  = osc_switch_pkg::RESP_OKAY;
      state_d.rdata  = 32'h0000_0000;
      if (s_axi_req.araddr == osc_switch_pkg::REQ_OFS) begin
        state_d.rdata[6:0] = {state_q.requested_source_sel,
                              state_q.requested_divider_sel};
      end else if (s_axi_req.araddr == osc_switch_pkg::STATUS_OFS) begin
        state_d.rdata[6:0] = {state_q.active_source_sel,
                              state_q.active_divider_sel};
      end else if (s_axi_req.araddr == osc_switch_pkg::STARTUP_OFS) begin
        state_d.rdata[osc_switch_pkg::STABLE_BIT]   = clock_stable;
        state_d.rdata[osc_switch_pkg::COUNTING_BIT] =
          (state_q.ost_state == osc_switch_pkg::ST_COUNT);
      end else begin
        state_d.rresp = osc_switch_pkg::RESP_SLVERR;
      end
    end
    // Start-up count
    case (state_q.ost_state)
      osc_switch_pkg::ST_COUNT: begin
        if (pin_rise) begin
          if (state_q.startup_oscillation_counter == ost_last) begin
            state_d.ost_state = osc_switch_pkg::ST_STABLE;
          end else begin
            state_d.startup_oscillation_counter =
              state_q.startup_oscillation_counter + 1'b1;
          end
        end
      end
      osc_switch_pkg::ST_STABLE: begin
        if (state_q.active_source_sel != state_q.requested_source_sel ||
            state_q.active_divider_sel != state_q.requested_divider_sel) begin
          state_d.active_source_sel  = state_q.requested_source_sel;
          state_d.active_divider_sel = state_q.requested_divider_sel;
        end
      end
      default: begin
        state_d.ost_state = osc_switch_pkg::ST_STABLE;
      end
    endcase
    if (wake_pulse && crystal_mode) begin
      state_d.ost_state                   = osc_switch_pkg::ST_COUNT;
      state_d.startup_oscillation_counter = '0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q                       <= '0;
      state_q.bresp                 <= osc_switch_pkg::RESP_OKAY;
      state_q.rresp                 <= osc_switch_pkg::RESP_OKAY;
      state_q.requested_source_sel  <= reset_source_config;
      state_q.requested_divider_sel <= reset_div;
      state_q.active_source_sel     <= reset_source_config;
      state_q.active_divider_sel    <= reset_div;
      state_q.ost_state             <= crystal_mode ? osc_switch_pkg::ST_COUNT :
                                       osc_switch_pkg::ST_STABLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence write_taken_s;
    wr_fire && (wr_addr == osc_switch_pkg::REQ_OFS) && wr_strb[0];
  endsequence

  sequence locked_write_s;
    write_taken_s ##0 (!switch_write_enable ||
      RESERVED_MAP[wr_data[osc_switch_pkg::SRC_MSB:osc_switch_pkg::SRC_LSB]]);
  endsequence

  property request_load_p;
    (write_taken_s ##0 (switch_write_enable &&
     !RESERVED_MAP[wr_data[osc_switch_pkg::SRC_MSB:osc_switch_pkg::SRC_LSB]]))
    |=> (state_q.requested_source_sel == $past(wr_data[6:4])) &&
        (state_q.requested_divider_sel == $past(wr_data[3:0]));
  endproperty

  request_load_a: assert property (request_load_p)
    else $error("request fields did not take the written value");
  write_ignored_a: assert property (locked_write_s |=>
    $stable(state_q.requested_source_sel) && $stable(state_q.requested_divider_sel))
    else $error("refused request write changed the register");
  reset_source_a: assert property ($rose(aresetn) |->
    state_q.requested_source_sel == reset_source_config)
    else $error("requested source not loaded from reset configuration");
  reset_divider_a: assert property ($rose(aresetn) |->
    state_q.requested_divider_sel == reset_div)
    else $error("requested divider reset value wrong");
  status_reset_a: assert property ($rose(aresetn) |->
    {state_q.active_source_sel, state_q.active_divider_sel} ==
    {state_q.requested_source_sel, state_q.requested_divider_sel})
    else $error("status reset differs from request reset");
  ost_complete_a: assert property ($rose(clock_stable) |->
    $past(state_q.startup_oscillation_counter) == ost_last && $past(pin_rise))
    else $error("start-up ended before the full count");
  wake_restart_a: assert property (wake_pulse && crystal_mode |=>
    state_q.ost_state == osc_switch_pkg::ST_COUNT &&
    state_q.startup_oscillation_counter == '0)
    else $error("wake-up did not restart the start-up count");
  no_wait_a: assert property (!crystal_mode |-> clock_stable)
    else $error("non-crystal mode waits on start-up count");
  status_hold_a: assert property (!clock_stable |=>
    $stable(state_q.active_source_sel) && $stable(state_q.active_divider_sel))
    else $error("status changed during start-up");
  status_follow_a: assert property (clock_stable && !wr_fire && !wake_pulse
    |=> ##1 state_q.active_source_sel == $past(state_q.requested_source_sel, 2))
    else $error("status did not follow the request");
  bit7_zero_a: assert property (s_axi_rsp.rvalid |->
    s_axi_rsp.rdata[31:7] == 25'h0)
    else $error("unimplemented read bits not zero");

endmodule

/* File: verification/xtal_model.sv */
// Purpose: Crystal resonator model that drives the crystal input pin
// Assumes: Oscillates only while run is high
// Notes:   The pin rests low while the resonator is stopped
`timescale 1ns/1ps
module xtal_model #(
  parameter int HALF_NS = 70
) (
  input  wire logic run,
  output logic      pin
);
  // Start 5 ns off the clock grid so pin edges never meet a clock edge
  initial begin
    pin = 1'b0;
    #5;
    forever begin
      #(HALF_NS);
      pin = run ? ~pin : 1'b0;
    end
  end
endmodule

/* File: verification/tb.sv */
// Purpose: Self-checking bench for the oscillator switch request block
// Assumes: Start-up count shortened to 4 crystal edges
// Notes:   Register access through AXI4-Lite tasks
`timescale 1ns/1ps
module tb;
  logic                        aclk;
  logic                        aresetn;
  osc_switch_pkg::axi_req_type req;
  osc_switch_pkg::axi_rsp_type rsp;
  logic [2:0]                  rsc;
  logic                        swe;
  logic [1:0]                  mode;
  logic                        wake;
  logic                        xrun;
  logic                        pin;
  logic                        stable;
  logic [2:0]                  asrc;
  logic [3:0]                  adiv;
  logic [31:0]                 rdat;
  logic [1:0]                  resp;
  logic [3:0]                  wmask;
  int                          bad_count;
  int                          checks;
  int                          cycles;
  int                          edges;

  osc_switch_ctrl #(
    .OST_CYCLES(4)
  ) DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_req(req), .s_axi_rsp(rsp),
    .reset_source_config(rsc), .switch_write_enable(swe),
    .crystal_mode_cfg(mode), .wake_pulse(wake), .crystal_input_pin(pin),
    .clock_stable(stable), .active_source_sel(asrc), .active_divider_sel(adiv)
  );

  xtal_model xtal (.run(xrun), .pin(pin));

  always #10 aclk = ~aclk;
  always @(posedge pin) edges++;

  // --------------------------------------------------------------
  // Bus and check tasks
  // --------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= wmask;
    req.bready  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready) begin
        aw_ok = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (req.wvalid && rsp.wready) begin
        w_ok = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (rsp.bvalid !== 1'b1);
    resp = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do @(posedge aclk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge aclk); while (rsp.rvalid !== 1'b1);
    rdat = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  task automatic rst(input logic [2:0] s, input logic [1:0] m);
    @(posedge aclk);
    aresetn <= 1'b0;
    xrun    <= 1'b0;
    rsc     <= s;
    mode    <= m;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    xrun    <= (m != 2'h0);
    edges = 0;
    @(posedge aclk);
  endtask

  task automatic wait_stable;
    int k;
    k = 0;
    while (stable !== 1'b1 && k < 400) begin
      @(posedge aclk);
      k++;
    end
    chk("stable_wait", stable, 32'h1);
  endtask

  task automatic pulse_wake;
    @(posedge aclk);
    wake <= 1'b1;
    @(posedge aclk);
    wake <= 1'b0;
    edges = 0;
    repeat (3) @(posedge aclk);
  endtask

  task automatic complete_run;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      complete_run();
    end
  end

  // --------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    req = '0;
    wmask = 4'hf;
    rsc = 3'h6;
    swe = 1'b1;
    mode = 2'h0;
    wake = 1'b0;
    xrun = 1'b0;
    bad_count = 0;
    checks = 0;
    cycles = 0;
    edges = 0;
    rst(3'h6, 2'h0);
    chk("stable", stable, 32'h1);
    rd(osc_switch_pkg::REQ_OFS);
    chk("req", rdat, 32'h62);
    chk("rresp_ok", resp, osc_switch_pkg::RESP_OKAY);
    rd(osc_switch_pkg::STATUS_OFS);
    chk("status", rdat, 32'h62);
    rd(osc_switch_pkg::STARTUP_OFS);
    chk("startup", rdat[0], 32'h1);
    pulse_wake();
    chk("stable_wake", stable, 32'h1);
    wr(osc_switch_pkg::REQ_OFS, 32'h25);
    chk("bresp", resp, osc_switch_pkg::RESP_OKAY);
    rd(osc_switch_pkg::REQ_OFS);
    chk("req", rdat, 32'h25);
    rd(osc_switch_pkg::STATUS_OFS);
    chk("status", rdat, 32'h25);
    chk("active", {asrc, adiv}, 32'h25);
    wr(osc_switch_pkg::REQ_OFS, 32'hff);
    rd(osc_switch_pkg::REQ_OFS);
    chk("req", rdat, 32'h7f);
    rd(osc_switch_pkg::STATUS_OFS);
    chk("status", rdat, 32'h7f);
    for (int c = 3; c <= 4; c++) begin
      wr(osc_switch_pkg::REQ_OFS, {24'h0, 1'b0, 3'(c), 4'h1});
      rd(osc_switch_pkg::REQ_OFS);
      chk("req_resv", rdat, 32'h7f);
    end
    swe <= 1'b0;
    wr(osc_switch_pkg::REQ_OFS, 32'h11);
    rd(osc_switch_pkg::REQ_OFS);
    chk("req_locked", rdat, 32'h7f);
    swe <= 1'b1;
    wr(osc_switch_pkg::STATUS_OFS, 32'h11);
    rd(osc_switch_pkg::STATUS_OFS);
    chk("status_ro", rdat, 32'h7f);
    wmask = 4'he;
    wr(osc_switch_pkg::REQ_OFS, 32'h11);
    wmask = 4'hf;
    rd(osc_switch_pkg::REQ_OFS);
    chk("req_strb", rdat, 32'h7f);
    rd(8'h0c);
    chk("rresp", resp, osc_switch_pkg::RESP_SLVERR);
    wr(8'h0c, 32'h11);
    chk("bresp", resp, osc_switch_pkg::RESP_SLVERR);
    for (int m = 1; m <= 3; m++) begin
      rst(3'h2, 2'(m));
      chk("stable", stable, 32'h0);
      rd(osc_switch_pkg::REQ_OFS);
      chk("req", rdat, 32'h20);
      wr(osc_switch_pkg::REQ_OFS, 32'h25);
      rd(osc_switch_pkg::STATUS_OFS);
      chk("status_early", rdat, 32'h20);
      rd(osc_switch_pkg::STARTUP_OFS);
      chk("startup_count", rdat, 32'h2);
      wait_stable();
      chk("edges", edges, 32'd4);
      repeat (2) @(posedge aclk);
      rd(osc_switch_pkg::STATUS_OFS);
      chk("status", rdat, 32'h25);
    end
    pulse_wake();
    chk("stable_wake", stable, 32'h0);
    wait_stable();
    chk("wake_edges", (edges >= 3 && edges <= 5), 32'h1);
    complete_run();
  end
endmodule
